// >>> design/pmwc_pkg.sv
package pmwc_pkg;
  // Register map of the host-facing port
  localparam logic [7:0]  PMWC_ADDR_BYTE_TEST  = 8'h64;
  localparam logic [7:0]  PMWC_ADDR_HW_CONFIG  = 8'h74;
  localparam logic [7:0]  PMWC_ADDR_PM_CONTROL = 8'h84;
  // Field positions
  localparam int          PMWC_POS_STATE       = 12;
  localparam int          PMWC_POS_XCVR_RST    = 10;
  localparam int          PMWC_POS_RWAKE_EN    = 9;
  localparam int          PMWC_POS_ENERGY_EN   = 8;
  localparam int          PMWC_POS_BUF_TYPE    = 6;
  localparam int          PMWC_POS_CAUSE       = 4;
  localparam int          PMWC_POS_PULSE       = 3;
  localparam int          PMWC_POS_POLARITY    = 2;
  localparam int          PMWC_POS_PIN_EN      = 1;
  localparam int          PMWC_POS_READY       = 0;
  // Writable bits mask, reserved bits read zero
  localparam logic [31:0] PMWC_RW_MASK         = 32'h0000_374e;
  localparam logic [31:0] PMWC_RESET_VALUE     = 32'h0000_0000;
  // Power state codes
  localparam logic [1:0]  PMWC_STATE_NORMAL    = 2'h0;
  localparam logic [1:0]  PMWC_STATE_FRAME     = 2'h1;
  localparam logic [1:0]  PMWC_STATE_ENERGY    = 2'h2;
  // Wake cause codes
  localparam logic [1:0]  PMWC_CAUSE_ENERGY    = 2'h1;
  localparam logic [1:0]  PMWC_CAUSE_FRAME     = 2'h2;
  // Timing
  localparam int          PMWC_CLK_HZ          = 25_000_000;
  localparam int          PMWC_XCVR_RST_NS     = 100_000;
  localparam int          PMWC_XCVR_RST_CYC    =
    (PMWC_XCVR_RST_NS * 25 + 999) / 1000;
  localparam int          PMWC_PULSE_MS        = 50;
  localparam int          PMWC_PULSE_CYC       = PMWC_PULSE_MS * (PMWC_CLK_HZ / 1000);
  localparam int          PMWC_SETTLE_CYC      = 16;
endpackage : pmwc_pkg

// >>> design/pmwc_if.sv
`timescale 1ns/1ps
interface pmwc_if;
  logic        cs;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        rvalid;
  logic        wake_pin_o;
  logic        wake_pin_oe;
  logic        wake_interrupt;
  logic        xcvr_reset;
  // Wire level: pull-up when nobody drives
  wire         wake_event_pin = wake_pin_oe ? wake_pin_o : 1'b1;
  modport device (
    input  cs, wr, rd, addr, wdata,
    output rdata, rvalid, wake_pin_o, wake_pin_oe, wake_interrupt, xcvr_reset
  );
  modport host (
    output cs, wr, rd, addr, wdata,
    input  rdata, rvalid, wake_event_pin, wake_interrupt, xcvr_reset
  );
endinterface : pmwc_if

// >>> design/pmwc_device.sv
`timescale 1ns/1ps
// What this block does
// - Power-state field picks normal, frame, energy
// - Host never writes power-state code 11b
// - Byte-test write wakes from reduced power
// - Host writes only byte-test/control while unready
// - Transceiver reset held 100us, self-clears
// - Transceiver-reset writes ignored while set
// - Remote wake drives pin, always interrupt
// - Energy detect drives pin, always interrupt
// - Buffer-type clear: open-drain, active low
// - Push-pull polarity bit sets active level
// - Wake-cause field encodes event source
// - Cause cleared by one, only when ready
// - Cause clears only with sources cleared
// - Pulse style gives 50ms pulse, else static
// - Pin released on cause or enable clear
// - Pin enable does not affect interrupt
// - Ready set after settling; else access invalid
// - Control register readable in all states
// - First read required before writes act
// - Host reads only config/control while unready
module pmwc_device #(
  parameter int PULSE_CYC  = pmwc_pkg::PMWC_PULSE_CYC,
  parameter int SETTLE_CYC = pmwc_pkg::PMWC_SETTLE_CYC
) (
  input  wire logic clk_sys_in,
  input  wire logic rstn_in,
  input  wire logic ce_in,
  input  wire logic remote_wake_evt_in,
  input  wire logic energy_evt_in,
  output logic      [1:0] power_state_sel_out,
  pmwc_if.device    bus
);
  typedef enum logic [1:0] {
    PMWC_ST_SETTLE = 2'b00,
    PMWC_ST_READY  = 2'b01,
    PMWC_ST_LOW    = 2'b11
  } pmwc_state_type;

  pmwc_state_type state_q;
  logic [1:0]     mode_q;
  logic           xrst_q;
  logic [15:0]    xrst_cnt_q;
  logic [5:0]     ctl_q;
  logic [1:0]     cause_q;
  logic           armed_q;
  logic           pin_act_q;
  logic [23:0]    pulse_cnt_q;
  logic [15:0]    settle_q;
  logic           irq_q;
  logic [31:0]    rdata_q;
  logic           rvalid_q;

  wire ready      = (state_q == PMWC_ST_READY);
  wire wr_ctl     = bus.cs && bus.wr && bus.addr == pmwc_pkg::PMWC_ADDR_PM_CONTROL;
  wire wr_bt      = bus.cs && bus.wr && bus.addr == pmwc_pkg::PMWC_ADDR_BYTE_TEST;
  wire rd_any     = bus.cs && bus.rd;
  wire wr_ok      = wr_ctl && ready && armed_q;
  wire rwake_en   = ctl_q[3];
  wire energy_en  = ctl_q[2];
  wire buf_pp     = ctl_q[1];
  wire pulse_sty  = ctl_q[0];
  wire polarity   = ctl_q[5];
  wire pin_en     = ctl_q[4];
  wire ev_rwake   = rwake_en && remote_wake_evt_in;
  wire ev_energy  = energy_en && energy_evt_in;
  // clear when ready and sources quiet
  wire [1:0] clr  = (wr_ok && !remote_wake_evt_in && !energy_evt_in) ?
                    bus.wdata[pmwc_pkg::PMWC_POS_CAUSE +: 2] : 2'b00;
  // cause encoding, set wins over clear
  wire [1:0] set  = {ev_rwake, ev_energy};
  wire [1:0] cause_d = (cause_q & ~clr) | set;
  wire [31:0] ctl_rd = {18'h0, mode_q, 1'b0, xrst_q, rwake_en, energy_en, 1'b0,
                        buf_pp, cause_q, pulse_sty, polarity, pin_en, ready};
  wire [31:0] mwd    = bus.wdata & pmwc_pkg::PMWC_RW_MASK;

  wire [1:0]  mode_wr     = mwd[pmwc_pkg::PMWC_POS_STATE +: 2];
  wire        sleep_req   = wr_ok && mode_wr != pmwc_pkg::PMWC_STATE_NORMAL;
  wire        any_ev      = ev_rwake || ev_energy;
  wire        wake_req    = wr_bt || any_ev;
  wire        settle_done = settle_q >= 16'(SETTLE_CYC - 1);
  wire [5:0]  ctl_wd      = {mwd[pmwc_pkg::PMWC_POS_POLARITY], mwd[pmwc_pkg::PMWC_POS_PIN_EN],
                             mwd[pmwc_pkg::PMWC_POS_RWAKE_EN], mwd[pmwc_pkg::PMWC_POS_ENERGY_EN],
                             mwd[pmwc_pkg::PMWC_POS_BUF_TYPE], mwd[pmwc_pkg::PMWC_POS_PULSE]};
  wire        xrst_wr     = wr_ok && mwd[pmwc_pkg::PMWC_POS_XCVR_RST];
  wire        xrst_done   = xrst_cnt_q >= 16'(pmwc_pkg::PMWC_XCVR_RST_CYC - 1);
  wire        pulse_done  = pulse_cnt_q >= 24'(PULSE_CYC - 1);
  wire        live        = (cause_d[1] && rwake_en) || (cause_d[0] && energy_en);
  wire [31:0] rd_sel      = (rd_any && bus.addr == pmwc_pkg::PMWC_ADDR_PM_CONTROL) ?
                            ctl_rd : 32'h0;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      state_q <= PMWC_ST_SETTLE;
      settle_q <= '0;
      mode_q <= pmwc_pkg::PMWC_STATE_NORMAL;
      armed_q <= 1'b0;
    end else if (ce_in) begin
      case (state_q)
        PMWC_ST_SETTLE: begin
          settle_q <= settle_q + 16'h1;
          if (settle_done) begin
            state_q <= PMWC_ST_READY;
            armed_q <= 1'b0;
          end
        end
        PMWC_ST_READY: begin
          settle_q <= '0;
          if (rd_any) begin
            armed_q <= 1'b1;
          end
          if (sleep_req) begin
            mode_q <= mode_wr;
            state_q <= PMWC_ST_LOW;
          end
        end
        PMWC_ST_LOW: begin
          // wake by byte-test write or event
          if (wake_req) begin
            mode_q <= pmwc_pkg::PMWC_STATE_NORMAL;
            state_q <= PMWC_ST_SETTLE;
          end
        end
        default: state_q <= PMWC_ST_SETTLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      ctl_q <= '0;
      cause_q <= '0;
    end else if (ce_in) begin
      cause_q <= cause_d;
      if (wr_ok) begin
        ctl_q <= ctl_wd;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      xrst_q <= 1'b0;
      xrst_cnt_q <= '0;
    end else if (ce_in) begin
      if (xrst_q) begin
        xrst_cnt_q <= xrst_cnt_q + 16'h1;
        if (xrst_done) begin
          xrst_q <= 1'b0;
        end
      end else if (xrst_wr) begin
        xrst_q <= 1'b1;
        xrst_cnt_q <= '0;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      pin_act_q <= 1'b0;
      pulse_cnt_q <= '0;
      irq_q <= 1'b0;
    end else if (ce_in) begin
      irq_q <= |cause_d;
      if (!live) begin
        pin_act_q <= 1'b0;
      end else if (any_ev) begin
        pin_act_q <= 1'b1;
        pulse_cnt_q <= '0;
      end else if (pin_act_q && pulse_sty) begin
        pulse_cnt_q <= pulse_cnt_q + 24'h1;
        if (pulse_done) begin
          pin_act_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end else if (ce_in) begin
      rvalid_q <= rd_any;
      rdata_q <= rd_sel;
    end
  end

  wire pin_on = pin_act_q && pin_en;
  assign bus.wake_pin_o     = buf_pp ? (pin_on ~^ polarity) : 1'b0;
  assign bus.wake_pin_oe    = buf_pp ? 1'b1 : pin_on;
  assign bus.wake_interrupt = irq_q;
  assign bus.xcvr_reset     = xrst_q;
  assign bus.rdata          = rdata_q;
  assign bus.rvalid         = rvalid_q;
  assign power_state_sel_out = mode_q;
endmodule : pmwc_device

// >>> design/pmwc_host.sv
`timescale 1ns/1ps
module pmwc_host (
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  input  wire logic        ce_in,
  input  wire logic        req_in,
  input  wire logic        req_wr_in,
  input  wire logic [7:0]  req_addr_in,
  input  wire logic [31:0] req_wdata_in,
  output logic             req_ready_out,
  output logic             req_refused_out,
  output logic [31:0]      rsp_data_out,
  output logic             rsp_valid_out,
  pmwc_if.host             bus
);
  logic        cs_q;
  logic        wr_q;
  logic        rd_q;
  logic [7:0]  addr_q;
  logic [31:0] wdata_q;
  logic        ready_q;
  logic        refused_q;
  logic [31:0] rsp_q;
  logic        rsp_v_q;

  wire addr_ctl = req_addr_in == pmwc_pkg::PMWC_ADDR_PM_CONTROL;
  wire addr_cfg = req_addr_in == pmwc_pkg::PMWC_ADDR_HW_CONFIG;
  wire addr_bt  = req_addr_in == pmwc_pkg::PMWC_ADDR_BYTE_TEST;
  wire allow    = ready_q || (req_wr_in ? (addr_bt || addr_ctl) : (addr_ctl || addr_cfg));
  wire bad_mode = req_wr_in && addr_ctl &&
                  req_wdata_in[pmwc_pkg::PMWC_POS_STATE +: 2] == 2'b11;
  wire go       = req_in && ce_in && allow && !bad_mode;

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      cs_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
      refused_q <= 1'b0;
    end else if (ce_in) begin
      cs_q <= go;
      wr_q <= go && req_wr_in;
      rd_q <= go && !req_wr_in;
      refused_q <= req_in && !go;
      if (go) begin
        addr_q <= req_addr_in;
        wdata_q <= req_wdata_in;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      ready_q <= 1'b0;
      rsp_q <= '0;
      rsp_v_q <= 1'b0;
    end else if (ce_in) begin
      rsp_v_q <= bus.rvalid;
      if (bus.rvalid) begin
        rsp_q <= bus.rdata;
        if (addr_q == pmwc_pkg::PMWC_ADDR_PM_CONTROL) begin
          ready_q <= bus.rdata[pmwc_pkg::PMWC_POS_READY];
        end
      end
      if (go && req_wr_in && addr_ctl && req_wdata_in[13:12] != 2'b00) begin
        ready_q <= 1'b0;
      end
    end
  end

  assign bus.cs          = cs_q;
  assign bus.wr          = wr_q;
  assign bus.rd          = rd_q;
  assign bus.addr        = addr_q;
  assign bus.wdata       = wdata_q;
  assign req_ready_out   = 1'b1;
  assign req_refused_out = refused_q;
  assign rsp_data_out    = rsp_q;
  assign rsp_valid_out   = rsp_v_q;
endmodule : pmwc_host

// >>> testbench/pmwc_asserts.sv
`timescale 1ns/1ps
module pmwc_asserts (
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  input  wire logic        cs,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic [31:0] rdata,
  input  wire logic        rvalid,
  input  wire logic        wake_interrupt,
  input  wire logic        xcvr_reset
);
  localparam int XCVR_CYC = pmwc_pkg::PMWC_XCVR_RST_CYC;
  logic [15:0] hold_q;
  wire         ctl_wr = cs && wr && addr == pmwc_pkg::PMWC_ADDR_PM_CONTROL;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // Transceiver reset length
  always_ff @(posedge clk_sys_in) begin
    hold_q <= (rstn_in && xcvr_reset) ? hold_q + 16'h1 : 16'h0;
  end
  property p_rd_ans; cs && rd |=> rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rv_src; rvalid |-> $past(cs && rd); endproperty
  a_rv_src: assert property (p_rv_src) else $error("answer without read");
  property p_resv;
    rvalid && $past(addr) == pmwc_pkg::PMWC_ADDR_PM_CONTROL |->
      (rdata & ~32'h0000_377f) == 32'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set");
  property p_other;
    rvalid && $past(addr) != pmwc_pkg::PMWC_ADDR_PM_CONTROL |-> rdata == 32'h0;
  endproperty
  a_other: assert property (p_other) else $error("other address not zero");
  property p_rst_src; $rose(xcvr_reset) |-> $past(ctl_wr && wdata[10]); endproperty
  a_rst_src: assert property (p_rst_src) else $error("reset without write");
  property p_rst_max; xcvr_reset |-> hold_q < XCVR_CYC + 2; endproperty
  a_rst_max: assert property (p_rst_max) else $error("reset held too long");
  property p_rst_min; $fell(xcvr_reset) |-> hold_q >= XCVR_CYC; endproperty
  a_rst_min: assert property (p_rst_min) else $error("reset too short");
  property p_int_clr; $fell(wake_interrupt) |-> $past(ctl_wr && |wdata[5:4]); endproperty
  a_int_clr: assert property (p_int_clr) else $error("interrupt dropped alone");
endmodule : pmwc_asserts

// >>> testbench/pmwc_tb_top.sv
`timescale 1ns/1ps
module pmwc_tb_top;
  logic        clk_sys_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        req_in = 1'b0;
  logic        req_wr_in = 1'b0;
  logic [7:0]  req_addr_in = 8'h0;
  logic [31:0] req_wdata_in = 32'h0;
  logic        remote_wake_evt_in = 1'b0;
  logic        energy_evt_in = 1'b0;
  logic        ce = 1'b1;
  logic        req_rdy;
  logic        refused;
  logic        ref_q = 1'b0;
  logic        rsp_valid;
  logic [31:0] rsp_data;
  logic [31:0] rd_q;
  logic [1:0]  state;
  int          n_errors = 0;
  int          samples_checked = 0;
  pmwc_if bus ();
  pmwc_device #(.PULSE_CYC(20), .SETTLE_CYC(16)) pmwc_device_i (.clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in), .ce_in(ce), .remote_wake_evt_in(remote_wake_evt_in),
    .energy_evt_in(energy_evt_in), .power_state_sel_out(state), .bus(bus.device));
  pmwc_host pmwc_host_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(ce),
    .req_in(req_in), .req_wr_in(req_wr_in), .req_addr_in(req_addr_in),
    .req_wdata_in(req_wdata_in), .req_ready_out(req_rdy), .req_refused_out(refused),
    .rsp_data_out(rsp_data), .rsp_valid_out(rsp_valid), .bus(bus.host));
  pmwc_asserts pmwc_asserts_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .cs(bus.cs),
    .wr(bus.wr), .rd(bus.rd), .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata),
    .rvalid(bus.rvalid), .wake_interrupt(bus.wake_interrupt), .xcvr_reset(bus.xcvr_reset));
  initial begin
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    rd_q <= req_in ? 32'hx : (rsp_valid === 1'b1 ? rsp_data : rd_q);
    ref_q <= req_in ? 1'b0 : (refused === 1'b1 ? 1'b1 : ref_q);
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : cyc
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    req_in <= 1'b1;
    req_wr_in <= w;
    req_addr_in <= a;
    req_wdata_in <= d;
    @(posedge clk_sys_in);
    req_in <= 1'b0;
    cyc(5);
  endtask : acc
  task automatic rdc(input string what, input logic [31:0] exp);
    acc(1'b0, 8'h84, 32'h0);
    chk(what, rd_q, exp);
  endtask : rdc
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic t_ready;
    rdc("early", 32'h0);
    cyc(20);
    acc(1'b1, 8'h84, 32'hffff_cbff);
    rdc("unread write", 32'h1);
    acc(1'b1, 8'h84, 32'hffff_cbff);
    rdc("config", 32'h0000_034f);
    $display("test ready done");
  endtask : t_ready
  task automatic t_xcvr;
    acc(1'b1, 8'h84, 32'h0000_074e);
    rdc("reset bit", 32'h0000_074f);
    acc(1'b1, 8'h84, 32'h0000_074e);
    cyc(2400);
    chk("reset held", 32'(bus.xcvr_reset), 32'h1);
    cyc(150);
    rdc("reset self clear", 32'h0000_034f);
    $display("test xcvr done");
  endtask : t_xcvr
  task automatic t_freeze;
    ce <= 1'b0;
    acc(1'b1, 8'h84, 32'h0000_074e);
    chk("frozen reset", 32'(bus.xcvr_reset), 32'h0);
    ce <= 1'b1;
    rdc("thawed", 32'h0000_034f);
    $display("test freeze done");
  endtask : t_freeze
  task automatic t_events;
    remote_wake_evt_in <= 1'b1;
    @(posedge clk_sys_in);
    remote_wake_evt_in <= 1'b0;
    cyc(2);
    chk("pulse pin", 32'(bus.wake_event_pin), 32'h1);
    chk("interrupt", 32'(bus.wake_interrupt), 32'h1);
    cyc(30);
    chk("pulse end", 32'(bus.wake_event_pin), 32'h0);
    energy_evt_in <= 1'b1;
    rdc("multi cause", 32'h0000_037f);
    acc(1'b1, 8'h84, 32'h0000_037e);
    rdc("held cause", 32'h0000_037f);
    remote_wake_evt_in <= 1'b0;
    energy_evt_in <= 1'b0;
    acc(1'b1, 8'h84, 32'h0000_037e);
    rdc("cleared", 32'h0000_034f);
    chk("interrupt off", 32'(bus.wake_interrupt), 32'h0);
    $display("test events done");
  endtask : t_events
  task automatic t_static;
    acc(1'b1, 8'h84, 32'h0000_0302);
    energy_evt_in <= 1'b1;
    @(posedge clk_sys_in);
    energy_evt_in <= 1'b0;
    cyc(30);
    chk("static low", 32'(bus.wake_event_pin), 32'h0);
    rdc("energy cause", 32'h0000_0313);
    acc(1'b1, 8'h84, 32'h0000_0202);
    chk("pin released", 32'(bus.wake_event_pin), 32'h1);
    chk("interrupt kept", 32'(bus.wake_interrupt), 32'h1);
    acc(1'b1, 8'h84, 32'h0000_0230);
    chk("interrupt off", 32'(bus.wake_interrupt), 32'h0);
    $display("test static done");
  endtask : t_static
  task automatic t_power;
    for (int c = 1; c < 3; c++) begin
      acc(1'b1, 8'h84, {18'h0, 2'(c), 12'h0});
      chk("state", 32'(state), 32'(c));
      acc(1'b0, 8'h84, 32'h0);
      chk("asleep ready", 32'(rd_q[0]), 32'h0);
      acc(1'b1, 8'h64, 32'h0);
      cyc(40);
      chk("woken", 32'(state), 32'h0);
      acc(1'b0, 8'h84, 32'h0);
      chk("awake ready", 32'({rd_q[13:12], rd_q[0]}), 32'h1);
    end
    acc(1'b1, 8'h84, 32'h0000_3000);
    chk("code 11 refused", 32'(ref_q), 32'h1);
    chk("host ready", 32'(req_rdy), 32'h1);
    $display("test power done");
  endtask : t_power
  initial begin
    cyc(16);
    rstn_in <= 1'b1;
    t_ready();
    t_xcvr();
    t_freeze();
    t_events();
    t_static();
    t_power();
    tally_and_finish();
  end
  initial begin
    cyc(10000);
    n_errors++;
    tally_and_finish();
  end
endmodule : pmwc_tb_top
